// >>> lsh_defines.vh
// Constants of the trigger, sorting and handler controller
`ifndef LSH_DEFINES_VH
`define LSH_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define LSH_A_CTRL 6'h00
`define LSH_A_TRIG 6'h04
`define LSH_A_NOM 6'h08
`define LSH_A_LIM1 6'h0c
`define LSH_A_LIM2 6'h10
`define LSH_A_LIM3 6'h14
`define LSH_A_SLO 6'h18
`define LSH_A_SHI 6'h1c
`define LSH_A_DELAY 6'h20
`define LSH_A_STAT 6'h24
`define LSH_A_RESULT 6'h28
`define LSH_A_PARAM 6'h2c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define LSH_C_SRC 1:0
`define LSH_C_EDGE 2
`define LSH_C_RAUTO 3
`define LSH_C_RMAN 7:4
`define LSH_C_DCR 8
`define LSH_C_PCT 9
`define LSH_C_DISP 11:10
`define LSH_C_AUX 12
`define LSH_C_HCLR 13
`define LSH_C_DISCH 14
`define LSH_C_APAR 15
`define LSH_C_FREQ 19:16
`define LSH_C_LEVEL 21:20
`define LSH_CTRL_W 22
`define LSH_CTRL_RST 22'h000008

// ----------------------------------------
// Encodings
// ----------------------------------------
`define LSH_SRC_INT 2'h0
`define LSH_SRC_EXT 2'h1
`define LSH_SRC_KEY 2'h2
`define LSH_SRC_BUS 2'h3
`define LSH_DISP_DIR 2'h0
`define LSH_DISP_ABS 2'h1
`define LSH_DISP_PCT 2'h2
`define LSH_PAIR_Z 2'h0
`define LSH_PAIR_LQ 2'h1
`define LSH_PAIR_CD 2'h2
`define LSH_RANGE_AC_MAX 4'h8
`define LSH_RANGE_DC_MAX 4'h9
`define LSH_FREQ_MAX 4'h9
`define LSH_LEVEL_MAX 2'h2
`define LSH_BIN_NONE 5'h1f

// ----------------------------------------
// Numeric thresholds and timing
// ----------------------------------------
`define LSH_ANGLE_LIM 32'sd500
`define LSH_Z_LIM 32'd1000
`define LSH_OVF_VAL 32'd99999
`define LSH_PCT_SCALE 64'd10000
`define LSH_CLK_HZ 25000000
`define LSH_DISCH_MS 15
`define LSH_DISCH_CYC ((`LSH_DISCH_MS * `LSH_CLK_HZ) / 1000)

`endif

// >>> lsh_far_side.sv
// Measurement engine and handler sampler that face the controller
module lsh_far_side (
	input wire hclk,
	input wire hresetn,
	input wire meas_start,
	input wire slow,
	input wire measurement_done_strobe_n,
	input wire [4:0] bin_n,
	output logic meas_done,
	output logic [4:0] seen_bin,
	output logic eom_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	int wait_cnt;
	logic eom_d;
	// ----------------------------------------
	// Engine answer and handler capture
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meas_done <= 1'b0;
			wait_cnt <= 0;
			seen_bin <= 5'h1f;
			eom_d <= 1'b1;
			eom_seen <= 1'b0;
		end else begin
			meas_done <= 1'b0;
			eom_d <= measurement_done_strobe_n;
			eom_seen <= eom_d && !measurement_done_strobe_n;
			// Handler latches bins on the falling strobe only
			if (eom_d && !measurement_done_strobe_n)
				seen_bin <= bin_n;
			// Slow answers keep the controller waiting in its measure state
			if (meas_start)
				wait_cnt <= slow ? 9 : 1;
			else if (wait_cnt == 1) begin
				meas_done <= 1'b1;
				wait_cnt <= 0;
			end else if (wait_cnt != 0)
				wait_cnt <= wait_cnt - 1;
		end
	end
endmodule // lsh_far_side

// >>> lsh_trigger_sort.v
// Trigger sequencing, bin sorting and handler port with AHB-Lite registers
// Contract
// - Internal source restarts a measurement as soon as the previous one ends.
// - External source runs exactly one measurement per qualifying trigger edge; the code merges edges arriving while busy into one pending start.
// - External trigger edge is selectable as rising or falling.
// - Bus source set only by remote; each trigger command starts one measurement.
// - Manual source runs one measurement per trigger key press.
// - Programmable wait after measurement; optional handler output clear afterwards.
// - Range auto or held; nine AC ranges, ten DC resistance ranges.
// - Pass bins one to three need primary and secondary within limits.
// - Primary outside all limits goes to reject bin.
// - Primary ok, secondary not: auxiliary bin if enabled, else reject.
// - Absolute sort compares signed difference from nominal with limits.
// - Percentage sort compares deviation as percent of nominal with limits.
// - Display shows direct value, absolute or percentage deviation.
// - Auto parameter: angle above 5 deg L-Q, below -5 C-D, else Z.
// - Auto parameter: impedance above one kilohm parallel, below series.
// - Near short or open keeps previously chosen parameters.
// - Manual parameter change switches automatic parameter mode off.
// - Discharge enabled holds sampling path discharged for 10 to 20 ms.
// - Handler bins and both strobes are active low outputs.
// - Non-percentage results beyond display range report 99999.
// - Test frequency selects one of ten fixed frequencies.
// - Test level selects one of three drive amplitudes.
// - Power-up restores last saved settings from nonvolatile storage; the code reloads only ctrl_reg, from restore_ctrl.
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`include "lsh_defines.vh"

module lsh_trigger_sort #(
	parameter DISCH_CYC = `LSH_DISCH_CYC,
	parameter DISP_LIMIT = `LSH_OVF_VAL
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire edge_input_trigger,
	input wire key_press_trigger,
	input wire key_src_load,
	input wire [1:0] key_src_sel,
	input wire restore_valid,
	input wire [31:0] restore_ctrl,
	input wire meas_done,
	input wire signed [31:0] meas_primary,
	input wire signed [31:0] meas_secondary,
	input wire signed [31:0] meas_angle,
	input wire [31:0] meas_zmag,
	input wire meas_near_short_open,
	input wire [3:0] meas_auto_range,
	output reg meas_start,
	output reg discharge_on,
	output reg [3:0] range_idx,
	output reg [3:0] freq_sel,
	output reg [1:0] level_sel,
	output reg [1:0] param_pair,
	output reg equiv_parallel,
	output reg [4:0] bin_n,
	output reg acquisition_done_strobe_n,
	output reg measurement_done_strobe_n
);

// ----------------------------------------
// States
// ----------------------------------------
localparam S_IDLE = 6'b000001;
localparam S_DISCH = 6'b000010;
localparam S_MEAS = 6'b000100;
localparam S_SORT = 6'b001000;
localparam S_EOM = 6'b010000;
localparam S_DELAY = 6'b100000;

// ----------------------------------------
// Functions
// ----------------------------------------
function [63:0] mag;
	input signed [63:0] v;
	begin
		mag = v[63] ? -v : v;
	end
endfunction

// Deviation within a symmetric limit, absolute or in 0.01 % units
function in_limit;
	input signed [63:0] dev;
	input [31:0] lim;
	input signed [63:0] nom;
	input pct;
	begin
		if (pct)
			in_limit = mag(dev) * `LSH_PCT_SCALE <= {32'h00000000, lim} * mag(nom);
		else
			in_limit = mag(dev) <= {32'h00000000, lim};
	end
endfunction

function [3:0] clamp4;
	input [3:0] v;
	input [3:0] mx;
	begin
		clamp4 = (v > mx) ? mx : v;
	end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg [`LSH_CTRL_W-1:0] ctrl_reg;
reg signed [31:0] nom_reg;
reg [31:0] lim_reg [0:2];
reg signed [31:0] slo_reg;
reg signed [31:0] shi_reg;
reg [31:0] delay_reg;
reg [31:0] result_reg;
reg [5:0] state_reg;
reg [31:0] cnt_reg;
reg pend_reg;
reg signed [31:0] prim_reg;
reg signed [31:0] sec_reg;
reg restored_reg;
reg [2:0] ext_sync_reg;
reg [2:0] key_sync_reg;
reg wr_pend_reg;
reg [5:0] wr_addr_reg;
reg bus_trig;

// ----------------------------------------
// Trigger sources
// ----------------------------------------
wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
wire ext_fall = ~ext_sync_reg[1] & ext_sync_reg[2];
wire ext_evt = ctrl_reg[`LSH_C_EDGE] ? ext_fall : ext_rise;
wire key_evt = key_sync_reg[1] & ~key_sync_reg[2];
wire [1:0] src = ctrl_reg[`LSH_C_SRC];
wire trig_evt = (src == `LSH_SRC_EXT && ext_evt) ||
	(src == `LSH_SRC_KEY && key_evt) ||
	(src == `LSH_SRC_BUS && bus_trig);
wire start_ok = (src == `LSH_SRC_INT) || pend_reg || trig_evt;

// ----------------------------------------
// Sorting
// ----------------------------------------
wire signed [63:0] dev = {{32{prim_reg[31]}}, prim_reg} - {{32{nom_reg[31]}}, nom_reg};
wire signed [63:0] nom64 = {{32{nom_reg[31]}}, nom_reg};
wire sec_ok = (sec_reg >= slo_reg) && (sec_reg <= shi_reg);
wire [2:0] prim_ok;
genvar gi;
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_bin
		assign prim_ok[gi] = in_limit(dev, lim_reg[gi], nom64, ctrl_reg[`LSH_C_PCT]);
	end
endgenerate

reg [4:0] bin_next;
always @* begin
	if (prim_ok[0] && sec_ok)
		bin_next = 5'h1e;
	else if (prim_ok[1] && sec_ok)
		bin_next = 5'h1d;
	else if (prim_ok[2] && sec_ok)
		bin_next = 5'h1b;
	else if (|prim_ok && ctrl_reg[`LSH_C_AUX])
		bin_next = 5'h17;
	else
		bin_next = 5'h0f;
end

// Divider runs in every display mode, its result used only in percentage display; guarded against zero nominal
wire signed [63:0] pct_full = (nom_reg == 32'sd0) ? 64'sd0 : (dev * 64'sd10000) / nom64;
reg [31:0] result_next;
always @* begin
	case (ctrl_reg[`LSH_C_DISP])
	`LSH_DISP_ABS: result_next = dev[31:0];
	`LSH_DISP_PCT: result_next = pct_full[31:0];
	default: result_next = prim_reg;
	endcase
	if (ctrl_reg[`LSH_C_DISP] != `LSH_DISP_PCT &&
		mag({{32{result_next[31]}}, result_next}) > DISP_LIMIT)
		result_next = `LSH_OVF_VAL;
end

// ----------------------------------------
// AHB-Lite slave
// ----------------------------------------
wire take = hsel && htrans[1] && hready;
reg [31:0] rd_mux;
always @* begin
	case (haddr[5:0])
	`LSH_A_CTRL: rd_mux = {10'h000, ctrl_reg};
	`LSH_A_NOM: rd_mux = nom_reg;
	`LSH_A_LIM1: rd_mux = lim_reg[0];
	`LSH_A_LIM2: rd_mux = lim_reg[1];
	`LSH_A_LIM3: rd_mux = lim_reg[2];
	`LSH_A_SLO: rd_mux = slo_reg;
	`LSH_A_SHI: rd_mux = shi_reg;
	`LSH_A_DELAY: rd_mux = delay_reg;
	`LSH_A_STAT: rd_mux = {12'h000, range_idx, equiv_parallel, param_pair, bin_n, pend_reg,
		discharge_on, state_reg};
	`LSH_A_RESULT: rd_mux = result_reg;
	`LSH_A_PARAM: rd_mux = {29'h00000000, equiv_parallel, param_pair};
	default: rd_mux = 32'h00000000;
	endcase
	if (haddr[31:6] != 26'h0000000)
		rd_mux = 32'h00000000;
end

always @* begin
	bus_trig = wr_pend_reg && wr_addr_reg == `LSH_A_TRIG;
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata <= 32'h00000000;
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		wr_pend_reg <= 1'b0;
		wr_addr_reg <= 6'h00;
	end else begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		wr_pend_reg <= take && hwrite && haddr[31:6] == 26'h0000000 && hsize == 3'h2;
		wr_addr_reg <= haddr[5:0];
		if (take && !hwrite)
			hrdata <= rd_mux;
	end
end

// ----------------------------------------
// Configuration
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		ctrl_reg <= `LSH_CTRL_RST;
		nom_reg <= 32'sd0;
		lim_reg[0] <= 32'h00000000;
		lim_reg[1] <= 32'h00000000;
		lim_reg[2] <= 32'h00000000;
		slo_reg <= 32'sd0;
		shi_reg <= 32'sd0;
		delay_reg <= 32'h00000000;
		restored_reg <= 1'b0;
	end else begin
		if (restore_valid && !restored_reg) begin
			ctrl_reg <= restore_ctrl[`LSH_CTRL_W-1:0];
			restored_reg <= 1'b1;
		end else if (key_src_load && key_src_sel != `LSH_SRC_BUS) begin
			ctrl_reg[`LSH_C_SRC] <= key_src_sel;
		end
		if (wr_pend_reg) begin
			case (wr_addr_reg)
			`LSH_A_CTRL: begin
				ctrl_reg <= hwdata[`LSH_CTRL_W-1:0];
				ctrl_reg[`LSH_C_FREQ] <= clamp4(hwdata[`LSH_C_FREQ], `LSH_FREQ_MAX);
				ctrl_reg[`LSH_C_LEVEL] <= (hwdata[`LSH_C_LEVEL] > `LSH_LEVEL_MAX) ?
					`LSH_LEVEL_MAX : hwdata[`LSH_C_LEVEL];
			end
			`LSH_A_NOM: nom_reg <= hwdata;
			`LSH_A_LIM1: lim_reg[0] <= hwdata;
			`LSH_A_LIM2: lim_reg[1] <= hwdata;
			`LSH_A_LIM3: lim_reg[2] <= hwdata;
			`LSH_A_SLO: slo_reg <= hwdata;
			`LSH_A_SHI: shi_reg <= hwdata;
			`LSH_A_DELAY: delay_reg <= hwdata;
			`LSH_A_PARAM: ctrl_reg[`LSH_C_APAR] <= 1'b0;
			default: ;
			endcase
		end
	end
end

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		ext_sync_reg <= 3'h0;
		key_sync_reg <= 3'h0;
	end else begin
		ext_sync_reg <= {ext_sync_reg[1:0], edge_input_trigger};
		key_sync_reg <= {key_sync_reg[1:0], key_press_trigger};
	end
end

// ----------------------------------------
// Measurement sequencer and handler port
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		state_reg <= S_IDLE;
		cnt_reg <= 32'h00000000;
		pend_reg <= 1'b0;
		prim_reg <= 32'sd0;
		sec_reg <= 32'sd0;
		result_reg <= 32'h00000000;
		meas_start <= 1'b0;
		discharge_on <= 1'b0;
		bin_n <= `LSH_BIN_NONE;
		acquisition_done_strobe_n <= 1'b1;
		measurement_done_strobe_n <= 1'b1;
		param_pair <= `LSH_PAIR_Z;
		equiv_parallel <= 1'b0;
	end else begin
		meas_start <= 1'b0;
		// Event arriving outside idle survives as a pending trigger; one in the idle start cycle is not kept
		if (state_reg != S_IDLE && trig_evt)
			pend_reg <= 1'b1;
		if (wr_pend_reg && wr_addr_reg == `LSH_A_PARAM) begin
			param_pair <= hwdata[1:0];
			equiv_parallel <= hwdata[2];
		end
		case (state_reg)
		S_IDLE: begin
			if (start_ok) begin
				pend_reg <= 1'b0;
				acquisition_done_strobe_n <= 1'b1;
				measurement_done_strobe_n <= 1'b1;
				if (ctrl_reg[`LSH_C_DISCH]) begin
					discharge_on <= 1'b1;
					cnt_reg <= DISCH_CYC - 1;
					state_reg <= S_DISCH;
				end else begin
					meas_start <= 1'b1;
					state_reg <= S_MEAS;
				end
			end
		end
		S_DISCH: begin
			if (cnt_reg == 32'h00000000) begin
				discharge_on <= 1'b0;
				meas_start <= 1'b1;
				state_reg <= S_MEAS;
			end else begin
				cnt_reg <= cnt_reg - 32'h00000001;
			end
		end
		S_MEAS: begin
			if (meas_done) begin
				prim_reg <= meas_primary;
				sec_reg <= meas_secondary;
				acquisition_done_strobe_n <= 1'b0;
				if (ctrl_reg[`LSH_C_APAR] && !meas_near_short_open) begin
					if (meas_angle > `LSH_ANGLE_LIM)
						param_pair <= `LSH_PAIR_LQ;
					else if (meas_angle < -`LSH_ANGLE_LIM)
						param_pair <= `LSH_PAIR_CD;
					else
						param_pair <= `LSH_PAIR_Z;
					if (meas_zmag > `LSH_Z_LIM)
						equiv_parallel <= 1'b1;
					else if (meas_zmag < `LSH_Z_LIM)
						equiv_parallel <= 1'b0;
				end
				state_reg <= S_SORT;
			end
		end
		S_SORT: begin
			bin_n <= bin_next;
			result_reg <= result_next;
			state_reg <= S_EOM;
		end
		S_EOM: begin
			// One cycle after the bins so the handler samples settled data
			measurement_done_strobe_n <= 1'b0;
			cnt_reg <= delay_reg;
			state_reg <= S_DELAY;
		end
		S_DELAY: begin
			if (cnt_reg == 32'h00000000) begin
				if (ctrl_reg[`LSH_C_HCLR]) begin
					bin_n <= `LSH_BIN_NONE;
					acquisition_done_strobe_n <= 1'b1;
					measurement_done_strobe_n <= 1'b1;
				end
				state_reg <= S_IDLE;
			end else begin
				cnt_reg <= cnt_reg - 32'h00000001;
			end
		end
		default: state_reg <= S_IDLE;
		endcase
	end
end

// ----------------------------------------
// Test settings
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		range_idx <= 4'h0;
		freq_sel <= 4'h0;
		level_sel <= 2'h0;
	end else begin
		freq_sel <= ctrl_reg[`LSH_C_FREQ];
		level_sel <= ctrl_reg[`LSH_C_LEVEL];
		range_idx <= clamp4(ctrl_reg[`LSH_C_RAUTO] ? meas_auto_range : ctrl_reg[`LSH_C_RMAN],
			ctrl_reg[`LSH_C_DCR] ? `LSH_RANGE_DC_MAX : `LSH_RANGE_AC_MAX);
	end
end

endmodule // lsh_trigger_sort

// >>> lsh_trigger_sort_sva.sv
// Port checker for the trigger and sorting controller
module lsh_trigger_sort_sva #(
	parameter DISCH_CYC = 20
) (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire meas_done,
	input wire meas_start,
	input wire discharge_on,
	input wire [3:0] range_idx,
	input wire [3:0] freq_sel,
	input wire [1:0] level_sel,
	input wire [1:0] param_pair,
	input wire [4:0] bin_n,
	input wire acquisition_done_strobe_n,
	input wire measurement_done_strobe_n
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	int dis_cnt;
	// ----------------------------------------
	// Helper count of discharge cycles
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dis_cnt <= 0;
		else
			dis_cnt <= discharge_on ? dis_cnt + 1 : 0;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_acq_low;
		$fell(acquisition_done_strobe_n);
	endsequence
	sequence s_eom_low;
		$fell(measurement_done_strobe_n);
	endsequence
	a_start_pulse: assert property (meas_start |=> !meas_start)
		else $error("start pulse longer than one cycle");
	a_acq_cause: assert property (s_acq_low |-> $past(meas_done))
		else $error("acquisition strobe without engine done");
	a_eom_order: assert property (s_acq_low |-> ##2 s_eom_low)
		else $error("end strobe not two cycles after acquisition strobe");
	a_bins_settled: assert property (s_eom_low |-> $stable(bin_n) && bin_n != 5'h1f)
		else $error("bins not settled at end strobe");
	a_one_bin: assert property (bin_n == 5'h1f || $onehot(~bin_n))
		else $error("more than one bin active");
	a_range_max: assert property (range_idx <= 4'h9)
		else $error("range index beyond ten ranges");
	a_freq_level: assert property (freq_sel <= 4'h9 && level_sel <= 2'h2)
		else $error("frequency or level out of set");
	a_pair_legal: assert property (param_pair != 2'h3)
		else $error("illegal parameter pair");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
	a_disch_len: assert property ($fell(discharge_on) |->
		dis_cnt >= DISCH_CYC - 1 && dis_cnt <= DISCH_CYC + 1)
		else $error("discharge length wrong");
endmodule // lsh_trigger_sort_sva

bind lsh_trigger_sort lsh_trigger_sort_sva #(.DISCH_CYC(DISCH_CYC)) u_sva (.hclk(hclk),
	.hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .meas_done(meas_done),
	.meas_start(meas_start), .discharge_on(discharge_on), .range_idx(range_idx),
	.freq_sel(freq_sel), .level_sel(level_sel), .param_pair(param_pair), .bin_n(bin_n),
	.acquisition_done_strobe_n(acquisition_done_strobe_n),
	.measurement_done_strobe_n(measurement_done_strobe_n));

// >>> testbench.sv
// Self-checking bench of the trigger and sorting controller
`include "lsh_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0, meas_near_short_open = 0;
	logic edge_input_trigger = 0, key_press_trigger = 0, pct, aux;
	logic [31:0] haddr = 0, hwdata = 0, rd, meas_zmag = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] auto_range = 4'h3;
	logic signed [31:0] meas_primary = 0, meas_secondary = 0, meas_angle = 0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, meas_start, meas_done, discharge_on, equiv_parallel, acq_n, eom_n, eom_seen;
	wire [3:0] range_idx, freq_sel;
	wire [1:0] level_sel, param_pair;
	wire [4:0] bin_n, seen_bin;
	int mismatches = 0, checked = 0, starts = 0, s0;
	longint lims[3] = '{32'ha, 32'h32, 32'h64};
	int ang[4] = '{600, -600, 600, 0};
	int zm[4] = '{2000, 10, 2000, 500};
	logic ns[4] = '{0, 0, 1, 0};
	logic [1:0] ep[4] = '{2'h1, 2'h2, 2'h2, 2'h0};
	logic eq[4] = '{1, 0, 0, 0};

	lsh_trigger_sort #(.DISCH_CYC(20)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.edge_input_trigger(edge_input_trigger), .key_press_trigger(key_press_trigger),
		.key_src_load(1'b0), .key_src_sel(2'h0), .restore_valid(1'b0), .restore_ctrl(32'h0),
		.meas_done(meas_done), .meas_primary(meas_primary), .meas_secondary(meas_secondary),
		.meas_angle(meas_angle), .meas_zmag(meas_zmag), .meas_near_short_open(meas_near_short_open),
		.meas_auto_range(auto_range), .meas_start(meas_start), .discharge_on(discharge_on),
		.range_idx(range_idx), .freq_sel(freq_sel), .level_sel(level_sel),
		.param_pair(param_pair), .equiv_parallel(equiv_parallel), .bin_n(bin_n),
		.acquisition_done_strobe_n(acq_n), .measurement_done_strobe_n(eom_n));
	lsh_far_side u_far (.hclk(hclk), .hresetn(hresetn), .meas_start(meas_start), .slow(slow),
		.measurement_done_strobe_n(eom_n), .bin_n(bin_n), .meas_done(meas_done),
		.seen_bin(seen_bin), .eom_seen(eom_seen));

	// ----------------------------------------
	// Clock, timeout, tasks and model
	// ----------------------------------------
	initial forever #20 hclk = ~hclk;
	always @(posedge hclk) if (meas_start === 1'b1) starts++;
	initial begin
		#2000000;
		mismatches++;
		print_verdict();
	end
	task chk(string what, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			mismatches++;
		end
	endtask
	task xfer(logic [31:0] a, logic w, logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task trig();
		int n;
		n = 0;
		xfer(`LSH_A_TRIG, 1'b1, 32'h0);
		do begin
			@(posedge hclk);
			n++;
		end while (eom_seen !== 1'b1 && n < 300);
		chk("eom wait", n < 300, 1);
	endtask
	// Bin chosen from integers: nominal 1000, secondary window -100..100
	function automatic logic [4:0] exp_bin(longint p, longint s, logic pc, logic ax);
		longint d;
		d = p > 1000 ? p - 1000 : 1000 - p;
		for (int i = 0; i < 3; i++)
			if (pc ? d * 10000 <= lims[i] * 10 * 1000 : d <= lims[i])
				return (s >= -100 && s <= 100) ? 5'h1f ^ (5'h1 << i) : (ax ? 5'h17 : 5'h0f);
		return 5'h0f;
	endfunction
	task print_verdict();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'hde94));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		xfer(`LSH_A_CTRL, 1'b0, 32'h0);
		chk("ctrl reset", rd, 32'h8);
		xfer(32'h30, 1'b0, 32'h0);
		chk("unmapped", rd, 32'h0);
		xfer(`LSH_A_NOM, 1'b1, 32'h3e8);
		xfer(`LSH_A_SLO, 1'b1, 32'hffffff9c);
		xfer(`LSH_A_SHI, 1'b1, 32'h64);
		$display("registers done");
		for (int i = 0; i < 16; i++) begin
			pct = i >= 8;
			aux = i[0];
			xfer(`LSH_A_CTRL, 1'b1, 32'hb | (aux << 12) | (pct << 9));
			for (int k = 0; k < 3; k++)
				xfer(`LSH_A_LIM1 + 4 * k, 1'b1, lims[k] * (pct ? 10 : 1));
			meas_primary <= 1000 + $urandom % 260 - 130;
			meas_secondary <= $urandom % 300 - 150;
			slow <= i[1];
			trig();
			chk("bin", seen_bin, exp_bin(meas_primary, meas_secondary, pct, aux));
		end
		$display("sorting done");
		for (int e = 0; e < 2; e++) begin
			xfer(`LSH_A_CTRL, 1'b1, 32'h9 | (e << 2));
			repeat (40) @(posedge hclk);
			s0 = starts;
			// Rise then fall; only the selected edge starts a measurement
			edge_input_trigger <= 1'b1;
			repeat (40) @(posedge hclk);
			chk("ext first", starts - s0, e == 0);
			edge_input_trigger <= 1'b0;
			repeat (40) @(posedge hclk);
			chk("ext second", starts - s0, 1);
		end
		xfer(`LSH_A_CTRL, 1'b1, 32'ha);
		repeat (40) @(posedge hclk);
		s0 = starts;
		key_press_trigger <= 1'b1;
		repeat (40) @(posedge hclk);
		key_press_trigger <= 1'b0;
		xfer(`LSH_A_TRIG, 1'b1, 32'h0);
		repeat (40) @(posedge hclk);
		chk("key", starts - s0, 1);
		s0 = starts;
		xfer(`LSH_A_CTRL, 1'b1, 32'h8);
		repeat (60) @(posedge hclk);
		chk("internal", starts - s0 >= 3, 1);
		xfer(`LSH_A_CTRL, 1'b1, 32'h800b);
		repeat (40) @(posedge hclk);
		$display("triggers done");
		for (int k = 0; k < 4; k++) begin
			meas_angle <= ang[k];
			meas_zmag <= zm[k];
			meas_near_short_open <= ns[k];
			trig();
			chk("pair", param_pair, ep[k]);
			chk("equiv", equiv_parallel, eq[k]);
		end
		xfer(`LSH_A_PARAM, 1'b1, 32'h1);
		xfer(`LSH_A_CTRL, 1'b0, 32'h0);
		chk("auto off", rd[15], 0);
		chk("manual pair", param_pair, 2'h1);
		$display("auto parameter done");
		xfer(`LSH_A_DELAY, 1'b1, 32'h8);
		xfer(`LSH_A_CTRL, 1'b1, 32'h600b);
		trig();
		chk("held", bin_n === 5'h1f, 0);
		repeat (15) @(posedge hclk);
		chk("cleared", bin_n, 5'h1f);
		$display("delay and discharge done");
		xfer(`LSH_A_RESULT, 1'b0, 32'h0);
		chk("result dir", rd, meas_primary);
		meas_primary <= 32'sd200000;
		xfer(`LSH_A_CTRL, 1'b1, 32'h40b);
		trig();
		xfer(`LSH_A_RESULT, 1'b0, 32'h0);
		chk("result ovf", rd, 32'd99999);
		meas_primary <= 32'sd1100;
		xfer(`LSH_A_CTRL, 1'b1, 32'h80b);
		trig();
		xfer(`LSH_A_RESULT, 1'b0, 32'h0);
		chk("result pct", rd, 32'd1000);
		xfer(`LSH_A_CTRL, 1'b1, 32'h3f00f3);
		repeat (2) @(posedge hclk);
		chk("range held", range_idx, 4'h8);
		chk("freq", freq_sel, 4'h9);
		chk("level", level_sel, 2'h2);
		auto_range <= 4'hc;
		xfer(`LSH_A_CTRL, 1'b1, 32'h10b);
		repeat (2) @(posedge hclk);
		chk("range dc", range_idx, 4'h9);
		$display("results and settings done");
		print_verdict();
	end
endmodule // testbench
